// ---- design/tcm_ch2_output_compare.sv ----
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// R1 - direction field picks output compare or capture
// R2 - clear enable: trigger high forces reference low
// R3 - mode field bits 14..12 selects reference behaviour
// R4 - reference active high; pins follow polarity bits
// R5 - frozen mode keeps reference unchanged
// R6 - mode 001 sets reference on match
// R7 - mode 010 clears reference on match
// R8 - mode 011 toggles reference on match
// R9 - mode 100 forces reference low
// R10 - mode 101 forces reference high
// R11 - PWM1: up low above compare, down opposite
// R12 - PWM2 inverts PWM1 behaviour
// R13 - mode writes ignored at lock 3, output
// R14 - PWM changes only on result change or entry
module tcm_ch2_output_compare
    import tcm_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // register port
    input  wire logic [7:0]       regAddr,
    input  wire logic [15:0]      regWdata,
    input  wire logic             regWr,
    input  wire logic             regRd,
    output logic      [15:0]      regRdata,
    // timer core
    input  wire logic [CNT_W-1:0] coreCount,
    input  wire logic             countDown,
    input  wire logic [CNT_W-1:0] compareValue,
    input  wire logic             filteredExternalTrigger,
    input  wire logic [1:0]       lockLevel,
    input  wire logic             ch2MainPolarity,
    input  wire logic             ch2ComplementPolarity,
    // channel outputs
    output logic                  ch2OutputReference,
    output logic                  ch2MainOutput,
    output logic                  ch2ComplementOutput,
    output logic                  ch2IsOutput
);

    // pwm comparison result: true when reference should be active
    function automatic logic pwmActive(input logic above, input logic down, input logic inv);
        logic act;
        act = down ? above : !above;
        return inv ? !act : act;
    endfunction

    logic [15:0] ctrl_r;
    logic [15:0] ctrlNxt;
    logic        ref_r;
    logic        refNxt;
    logic        pwmRes_r;
    logic [2:0]  prevMode_r;
    logic [15:0] rdNxt;

    // register decode
    wire         ctrlSel   = regAddr == CHAN_PAIR_MODE_CTRL_OFS;
    wire         statSel   = regAddr == CH2_OUT_STATUS_OFS;
    wire         ctrlWr    = regWr && ctrlSel;
    wire [1:0]   dirField  = ctrl_r[DIR_HI:DIR_LO];
    wire         isOutput  = dirField == DIR_OUTPUT; // R1
    wire         modeLock  = (lockLevel == LOCK_LEVEL_3) && isOutput; // R13
    wire [2:0]   modeField = ctrl_r[MODE_HI:MODE_LO]; // R3
    wire         clearEn   = ctrl_r[CLR_EN_BIT];

    // control write, mode field held under lock
    always_comb begin
        ctrlNxt = ctrl_r;
        if (ctrlWr) begin
            ctrlNxt = regWdata;
            if (modeLock) begin
                ctrlNxt[MODE_HI:MODE_LO] = modeField; // R13
            end
        end
    end

    // compare results
    wire         match     = coreCount == compareValue;
    wire         above     = coreCount > compareValue;
    wire         pwm2      = modeField == MODE_PWM2;
    wire         pwmNow    = pwmActive(above, countDown, pwm2); // R11 R12
    wire         isPwm     = (modeField == MODE_PWM1) || pwm2;
    wire         prevFroz  = prevMode_r == MODE_FROZEN;
    wire         pwmUpd    = (pwmNow != pwmRes_r) || prevFroz
                             || (prevMode_r != modeField); // R14

    // reference next value by mode
    always_comb begin
        refNxt = ref_r;
        unique case (tcm_mode_t'(modeField))
            MODE_FROZEN:   refNxt = ref_r; // R5
            MODE_SET:      if (match) refNxt = 1'b1; // R6
            MODE_CLEAR:    if (match) refNxt = 1'b0; // R7
            MODE_TOGGLE:   if (match) refNxt = !ref_r; // R8
            MODE_FORCE_LO: refNxt = 1'b0; // R9
            MODE_FORCE_HI: refNxt = 1'b1; // R10
            MODE_PWM1,
            MODE_PWM2:     if (pwmUpd) refNxt = pwmNow; // R14
        endcase
        if (!isOutput) begin
            refNxt = ref_r; // R1
        end
        if (clearEn && filteredExternalTrigger) begin
            refNxt = 1'b0; // R2
        end
    end

    // read mux
    always_comb begin
        rdNxt = 16'h0000;
        if (ctrlSel) begin
            rdNxt = ctrl_r;
        end else if (statSel) begin
            rdNxt[STAT_REF_BIT]  = ref_r;
            rdNxt[STAT_MAIN_BIT] = ch2MainOutput;
            rdNxt[STAT_COMP_BIT] = ch2ComplementOutput;
            rdNxt[STAT_OUT_BIT]  = isOutput;
        end
    end

    // control and read data registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r   <= CHAN_PAIR_MODE_CTRL_RST;
            regRdata <= 16'h0000;
        end else begin
            ctrl_r   <= ctrlNxt;
            regRdata <= regRd ? rdNxt : 16'h0000;
        end
    end

    // reference and pwm history
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_r      <= 1'b0;
            pwmRes_r   <= 1'b0;
            prevMode_r <= 3'h0;
        end else begin
            ref_r      <= refNxt;
            pwmRes_r   <= isPwm ? pwmNow : pwmRes_r;
            prevMode_r <= modeField;
        end
    end

    // outputs, reference active high, pins per polarity
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ch2OutputReference  <= 1'b0;
            ch2MainOutput       <= 1'b0;
            ch2ComplementOutput <= 1'b0;
            ch2IsOutput         <= 1'b0;
        end else begin
            ch2OutputReference  <= refNxt; // R4
            ch2MainOutput       <= refNxt ^ ch2MainPolarity; // R4
            ch2ComplementOutput <= !refNxt ^ ch2ComplementPolarity; // R4
            ch2IsOutput         <= isOutput;
        end
    end

endmodule

// ---- design/tcm_pkg.sv ----
package tcm_pkg;
    // register map
    localparam logic [7:0]  CHAN_PAIR_MODE_CTRL_OFS = 8'h18;
    localparam logic [7:0]  CH2_OUT_STATUS_OFS      = 8'h1C;
    localparam logic [15:0] CHAN_PAIR_MODE_CTRL_RST = 16'h0000;
    // field positions in the mode control register
    localparam int CLR_EN_BIT  = 15;
    localparam int MODE_HI     = 14;
    localparam int MODE_LO     = 12;
    localparam int DIR_HI      = 9;
    localparam int DIR_LO      = 8;
    // status register bits
    localparam int STAT_REF_BIT  = 0;
    localparam int STAT_MAIN_BIT = 1;
    localparam int STAT_COMP_BIT = 2;
    localparam int STAT_OUT_BIT  = 3;
    // lock level and direction codes
    localparam logic [1:0] LOCK_LEVEL_3  = 2'h3;
    localparam logic [1:0] DIR_OUTPUT    = 2'h0;
    // output compare modes
    typedef enum logic [2:0] {
        MODE_FROZEN   = 3'h0,
        MODE_SET      = 3'h1,
        MODE_CLEAR    = 3'h2,
        MODE_TOGGLE   = 3'h3,
        MODE_FORCE_LO = 3'h4,
        MODE_FORCE_HI = 3'h5,
        MODE_PWM1     = 3'h6,
        MODE_PWM2     = 3'h7
    } tcm_mode_t;
endpackage

// ---- dv/tcm_ch2_oc_properties.sv ----
`timescale 1ns/1ps
module tcm_ch2_oc_properties
    import tcm_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock, reset and register port
    input wire logic             core_clk, rst_n, regWr, regRd,
    input wire logic [7:0]       regAddr,
    input wire logic [15:0]      regWdata, regRdata,
    // timer core and channel outputs
    input wire logic [CNT_W-1:0] coreCount, compareValue,
    input wire logic [1:0]       lockLevel,
    input wire logic             countDown, filteredExternalTrigger, ch2MainPolarity,
    input wire logic             ch2OutputReference, ch2MainOutput
);
    logic [15:0] ctl_r;
    logic        prevGt_r, lv_r;
    // decoded helpers
    wire       gt  = coreCount > compareValue;
    wire       eq  = coreCount == compareValue;
    wire [2:0] md  = ctl_r[14:12];
    wire       out = ctl_r[9:8] == DIR_OUTPUT;
    wire       clr = ctl_r[15] & filteredExternalTrigger;
    wire       ok  = lv_r & out & !clr;
    wire       lck = lockLevel == LOCK_LEVEL_3 && out;
    // shadow of the control register, mode kept while locked
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r    <= CHAN_PAIR_MODE_CTRL_RST;
            prevGt_r <= 1'b0;
            lv_r     <= 1'b0;
        end else begin
            prevGt_r <= gt;
            lv_r     <= 1'b1;
            if (regWr && regAddr == CHAN_PAIR_MODE_CTRL_OFS)
                ctl_r <= lck ? {regWdata[15], md, regWdata[11:0]} : regWdata;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    trig_clear_a: assert property ($past(lv_r && clr) |-> !ch2OutputReference)
        else $error("trigger did not clear reference");
    frozen_hold_a: assert property ($past(ok && md == MODE_FROZEN) |-> $stable(ch2OutputReference))
        else $error("frozen reference moved");
    match_set_a: assert property ($past(ok && md == MODE_SET && eq) |-> ch2OutputReference)
        else $error("match did not set reference");
    match_clear_a: assert property ($past(ok && md == MODE_CLEAR && eq) |-> !ch2OutputReference)
        else $error("match did not clear reference");
    toggle_flip_a: assert property ($past(ok && md == MODE_TOGGLE && eq) |-> $changed(ch2OutputReference))
        else $error("match did not toggle reference");
    force_level_a: assert property ($past(ok && md[2:1] == 2'h2) |-> ch2OutputReference == $past(md[0]))
        else $error("forced level wrong");
    pwm_level_a: assert property ($past(ok && md[2:1] == 2'h3 && gt != prevGt_r) |->
        ch2OutputReference == $past(gt ^ !countDown ^ md[0]))
        else $error("pwm level wrong");
    pin_polarity_a: assert property (lv_r |-> ch2MainOutput == (ch2OutputReference ^ $past(ch2MainPolarity)))
        else $error("main pin polarity wrong");
    ctrl_read_a: assert property ($past(lv_r && regRd && regAddr == CHAN_PAIR_MODE_CTRL_OFS) |->
        regRdata == $past(ctl_r))
        else $error("control read back wrong");
endmodule

bind tcm_ch2_output_compare tcm_ch2_oc_properties #(.CNT_W(CNT_W)) tcm_ch2_oc_properties_i (.*);

// ---- dv/timer_channel2_output_compare_mode_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module timer_channel2_output_compare_mode_bench;
    import tcm_pkg::*;
    logic        core_clk = 0, rst_n = 0, regWr = 0, regRd = 0, countDown = 0;
    logic        filteredExternalTrigger = 0, ch2MainPolarity = 1, ch2ComplementPolarity = 0;
    logic        ch2OutputReference, ch2MainOutput, ch2ComplementOutput, ch2IsOutput;
    logic [7:0]  regAddr = 8'h00;
    logic [1:0]  lockLevel = 2'h0;
    logic [15:0] regWdata = 16'h0000, coreCount = 16'h0009, compareValue = 16'h0005, regRdata;
    int          bad_count = 0, tests_run = 0;
    tcm_ch2_output_compare tcm_ch2_output_compare_i (.*);
    always #2.5 core_clk = ~core_clk;
    // register bus cycles
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 `CHK("read", e, regRdata)
    endtask
    // set a mode, pass one compare match, check the reference
    task automatic step(input logic [15:0] c, input logic t, input logic x);
        wr(CHAN_PAIR_MODE_CTRL_OFS, c);
        filteredExternalTrigger <= t;
        repeat (2) @(posedge core_clk);
        coreCount <= 16'h0005;
        @(posedge core_clk);
        coreCount <= 16'h0009;
        repeat (2) @(posedge core_clk);
        #1 `CHK("ref", x, ch2OutputReference)
        `CHK("main", ~x, ch2MainOutput)
        `CHK("comp", ~x, ch2ComplementOutput)
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // watchdog
    initial begin
        #20000;
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(CHAN_PAIR_MODE_CTRL_OFS, 16'h0000);
        rd(8'h40, 16'h0000);
        step(16'h1000, 1'b0, 1'b1);
        step(16'h0000, 1'b0, 1'b1);
        step(16'h2000, 1'b0, 1'b0);
        step(16'h3000, 1'b0, 1'b1);
        step(16'h4000, 1'b0, 1'b0);
        step(16'h5000, 1'b0, 1'b1);
        step(16'h6000, 1'b0, 1'b0);
        step(16'h7000, 1'b0, 1'b1);
        step(16'hF000, 1'b1, 1'b0);
        rd(CH2_OUT_STATUS_OFS, 16'h000E);
        lockLevel <= LOCK_LEVEL_3;
        wr(CHAN_PAIR_MODE_CTRL_OFS, 16'h0000);
        rd(CHAN_PAIR_MODE_CTRL_OFS, 16'h7000);
        lockLevel <= 2'h0;
        wr(CHAN_PAIR_MODE_CTRL_OFS, 16'h0100);
        rd(CHAN_PAIR_MODE_CTRL_OFS, 16'h0100);
        `CHK("dir", 1'b0, ch2IsOutput)
        print_verdict();
    end
endmodule
